// ---- hw/hcr_pkg.sv ----
// shared constants and types for the register-port target
package hcr_pkg;
    localparam logic [6:0]  OWN_ADDR   = 7'h54;   // 1010100, fixed target address
    localparam logic [4:0]  MCODE_PFX  = 5'h01;   // 00001xxx high-rate entry code
    localparam logic [7:0]  PEAK_PTR   = 8'h07;
    localparam logic [11:0] PEAK_RST   = 12'h000;
    localparam logic [7:0]  PTR_RST    = 8'h00;
    localparam int          RES_W      = 12;
    localparam int          RES_MSB    = 11;
    localparam logic [3:0]  BITS_BYTE  = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK
    } hcr_state_t;
endpackage

// ---- hw/hcr_sync2.sv ----
// two-flop level synchroniser, one lane per bit
`timescale 1ns/10ps
module hcr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // no reset: the chain flushes within two edges and holds no control state
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            always_ff @(posedge clk_in) begin
                meta_q[i] <= d_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    endgenerate

    assign q_out = sync_q;
endmodule

// ---- hw/hcr_conv_cdc.sv ----
// carries conversion results from the converter clock to the system clock; one arriving mid-transfer is dropped
`timescale 1ns/10ps
module hcr_conv_cdc (
    input  wire logic                      sys_clk_in,
    input  wire logic                      rstn_in,
    input  wire logic                      conv_clk_in,
    input  wire logic                      conv_valid_in,
    input  wire logic [hcr_pkg::RES_W-1:0] conv_data_in,
    output logic                           res_valid_out,
    output logic      [hcr_pkg::RES_W-1:0] res_data_out
);
    logic                      conv_rstn_s;
    logic                      req_q;
    logic                      req_d;
    logic                      ack_s;
    logic                      req_s;
    logic [hcr_pkg::RES_W-1:0] hold_q;
    logic [hcr_pkg::RES_W-1:0] hold_d;
    logic                      seen_q;
    logic                      vld_q;
    logic                      vld_d;
    logic [hcr_pkg::RES_W-1:0] res_q;
    logic [hcr_pkg::RES_W-1:0] res_d;

    hcr_sync2 #(.W(1)) u_rst_sync (
        .clk_in (conv_clk_in),
        .d_in   (rstn_in),
        .q_out  (conv_rstn_s)
    );
    hcr_sync2 #(.W(1)) u_ack_sync (
        .clk_in (conv_clk_in),
        .d_in   (seen_q),
        .q_out  (ack_s)
    );
    hcr_sync2 #(.W(1)) u_req_sync (
        .clk_in (sys_clk_in),
        .d_in   (req_q),
        .q_out  (req_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // converter side: a result is taken only while no transfer is in flight;
    // a conversion that arrives while one is in flight is dropped, not queued
    always_comb begin
        req_d  = req_q;
        hold_d = hold_q;
        if (conv_valid_in && (req_q == ack_s)) begin
            hold_d = conv_data_in;
            req_d  = ~req_q;
        end
    end

    always_ff @(posedge conv_clk_in) begin
        if (!conv_rstn_s) begin
            req_q  <= 1'b0;
            hold_q <= hcr_pkg::PEAK_RST;
        end else begin
            req_q  <= req_d;
            hold_q <= hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system side: hold_q is stable while the toggles differ
    always_comb begin
        vld_d = 1'b0;
        res_d = res_q;
        if (req_s != seen_q) begin
            vld_d = 1'b1;
            res_d = hold_q;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            seen_q <= 1'b0;
            vld_q  <= 1'b0;
            res_q  <= hcr_pkg::PEAK_RST;
        end else begin
            seen_q <= req_s;
            vld_q  <= vld_d;
            res_q  <= res_d;
        end
    end

    assign res_valid_out = vld_q;
    assign res_data_out  = res_q;
endmodule

// ---- hw/hcr_target_port.sv ----
// two-wire target port with pointer-selected 16-bit registers and peak tracker
`timescale 1ns/10ps
module hcr_target_port (
    input  wire logic                      sys_clk_in,
    input  wire logic                      rstn_in,
    input  wire logic                      conv_clk_in,
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output logic                           sda_out,
    output logic                           sda_oe_out,
    input  wire logic                      conv_valid_in,
    input  wire logic [hcr_pkg::RES_W-1:0] conv_data_in,
    input  wire logic                      auto_mode_in,
    output logic      [hcr_pkg::RES_W-1:0] peak_value_out,
    output logic                           high_rate_mode_out
);
    logic                      scl_s;
    logic                      sda_s;
    logic                      scl_p_q;
    logic                      sda_p_q;
    logic                      start_det;
    logic                      stop_det;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      res_vld;
    logic [hcr_pkg::RES_W-1:0] res_data;

    hcr_pkg::hcr_state_t st_q;
    hcr_pkg::hcr_state_t st_d;
    logic [3:0]          cnt_q;
    logic [3:0]          cnt_d;
    logic [7:0]          sh_q;
    logic [7:0]          sh_d;
    logic [7:0]          tx_q;
    logic [7:0]          tx_d;
    logic                oe_q;
    logic                oe_d;
    logic [7:0]          ptr_q;
    logic [7:0]          ptr_d;
    logic [1:0]          idx_q;
    logic [1:0]          idx_d;
    logic [7:0]          hi_q;
    logic [7:0]          hi_d;
    logic [15:0]         snap_q;
    logic [15:0]         snap_d;
    logic                lo_next_q;
    logic                lo_next_d;
    logic                rw_q;
    logic                rw_d;
    logic                mack_q;
    logic                mack_d;
    logic                hs_q;
    logic                hs_d;
    logic                wr_q;
    logic                wr_d;
    logic [15:0]         wdata_q;
    logic [15:0]         wdata_d;
    logic [15:0]         rd_word;

    logic [hcr_pkg::RES_W-1:0] peak_q;
    logic [hcr_pkg::RES_W-1:0] peak_d;

    ////////////////////////////////////////////////////////////////////////////
    // line sampling and bus condition detection

    hcr_sync2 #(.W(2)) u_line_sync (
        .clk_in (sys_clk_in),
        .d_in   ({scl_in, sda_in}),
        .q_out  ({scl_s, sda_s})
    );

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // data edges while the clock stays high are conditions, never data
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign scl_rise  = scl_s && !scl_p_q;
    assign scl_fall  = !scl_s && scl_p_q;

    hcr_conv_cdc u_conv_cdc (
        .sys_clk_in    (sys_clk_in),
        .rstn_in       (rstn_in),
        .conv_clk_in   (conv_clk_in),
        .conv_valid_in (conv_valid_in),
        .conv_data_in  (conv_data_in),
        .res_valid_out (res_vld),
        .res_data_out  (res_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register read mux: only the peak register lives here, others read zero

    always_comb begin
        rd_word = 16'h0000;
        if (ptr_q == hcr_pkg::PEAK_PTR) begin
            rd_word = {4'h0, peak_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus protocol engine; the line only changes in the clock-low half
    // hold time is two to three system cycles after the clock fall

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        sh_d      = sh_q;
        tx_d      = tx_q;
        oe_d      = oe_q;
        ptr_d     = ptr_q;
        idx_d     = idx_q;
        hi_d      = hi_q;
        snap_d    = snap_q;
        lo_next_d = lo_next_q;
        rw_d      = rw_q;
        mack_d    = mack_q;
        hs_d      = hs_q;
        wr_d      = 1'b0;
        wdata_d   = wdata_q;
        if (start_det) begin
            // a repeated start keeps the rate flag as it is
            st_d  = hcr_pkg::ST_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end else if (stop_det) begin
            st_d = hcr_pkg::ST_IDLE;
            oe_d = 1'b0;
            hs_d = 1'b0;
        end else if (scl_rise) begin
            case (st_q)
                hcr_pkg::ST_ADDR, hcr_pkg::ST_WR: begin
                    sh_d  = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 4'h1;
                end
                hcr_pkg::ST_RD: begin
                    cnt_d = cnt_q + 4'h1;
                end
                hcr_pkg::ST_RD_ACK: begin
                    mack_d = !sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_q)
                hcr_pkg::ST_ADDR: begin
                    if (cnt_q == hcr_pkg::BITS_BYTE) begin
                        if (sh_q[7:1] == hcr_pkg::OWN_ADDR) begin
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                            st_d = hcr_pkg::ST_ADDR_ACK;
                        end else if (sh_q[7:3] == hcr_pkg::MCODE_PFX) begin
                            hs_d = 1'b1;
                            st_d = hcr_pkg::ST_IDLE;
                        end else begin
                            st_d = hcr_pkg::ST_IDLE;
                        end
                    end
                end
                hcr_pkg::ST_ADDR_ACK: begin
                    cnt_d = 4'h0;
                    if (rw_q) begin
                        // whole word frozen so both bytes belong together
                        snap_d    = rd_word;
                        tx_d      = rd_word[15:8];
                        oe_d      = !rd_word[15];
                        lo_next_d = 1'b1;
                        st_d      = hcr_pkg::ST_RD;
                    end else begin
                        idx_d = 2'h0;
                        oe_d  = 1'b0;
                        st_d  = hcr_pkg::ST_WR;
                    end
                end
                hcr_pkg::ST_WR: begin
                    if (cnt_q == hcr_pkg::BITS_BYTE) begin
                        oe_d = 1'b1;
                        st_d = hcr_pkg::ST_WR_ACK;
                        case (idx_q)
                            2'h0: begin
                                ptr_d = sh_q;
                                idx_d = 2'h1;
                            end
                            2'h1: begin
                                // a stop here leaves the register untouched
                                hi_d  = sh_q;
                                idx_d = 2'h2;
                            end
                            default: begin
                                wr_d    = 1'b1;
                                wdata_d = {hi_q, sh_q};
                                idx_d   = 2'h1;
                            end
                        endcase
                    end
                end
                hcr_pkg::ST_WR_ACK: begin
                    oe_d  = 1'b0;
                    cnt_d = 4'h0;
                    st_d  = hcr_pkg::ST_WR;
                end
                hcr_pkg::ST_RD: begin
                    if (cnt_q == hcr_pkg::BITS_BYTE) begin
                        oe_d = 1'b0;
                        st_d = hcr_pkg::ST_RD_ACK;
                    end else begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = !tx_q[6];
                    end
                end
                hcr_pkg::ST_RD_ACK: begin
                    cnt_d = 4'h0;
                    if (mack_q) begin
                        st_d = hcr_pkg::ST_RD;
                        if (lo_next_q) begin
                            tx_d      = snap_q[7:0];
                            oe_d      = !snap_q[7];
                            lo_next_d = 1'b0;
                        end else begin
                            snap_d    = rd_word;
                            tx_d      = rd_word[15:8];
                            oe_d      = !rd_word[15];
                            lo_next_d = 1'b1;
                        end
                    end else begin
                        oe_d = 1'b0;
                        st_d = hcr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            st_q      <= hcr_pkg::ST_IDLE;
            cnt_q     <= 4'h0;
            sh_q      <= 8'h00;
            tx_q      <= 8'h00;
            oe_q      <= 1'b0;
            ptr_q     <= hcr_pkg::PTR_RST;
            idx_q     <= 2'h0;
            hi_q      <= 8'h00;
            snap_q    <= 16'h0000;
            lo_next_q <= 1'b0;
            rw_q      <= 1'b0;
            mack_q    <= 1'b0;
            hs_q      <= 1'b0;
            wr_q      <= 1'b0;
            wdata_q   <= 16'h0000;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            sh_q      <= sh_d;
            tx_q      <= tx_d;
            oe_q      <= oe_d;
            ptr_q     <= ptr_d;
            idx_q     <= idx_d;
            hi_q      <= hi_d;
            snap_q    <= snap_d;
            lo_next_q <= lo_next_d;
            rw_q      <= rw_d;
            mack_q    <= mack_d;
            hs_q      <= hs_d;
            wr_q      <= wr_d;
            wdata_q   <= wdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peak tracker: a bus write lands first, then a same-cycle result is
    // compared against it, so a result arriving with a clear is not lost

    always_comb begin
        peak_d = peak_q;
        if (wr_q && (ptr_q == hcr_pkg::PEAK_PTR)) begin
            peak_d = wdata_q[hcr_pkg::RES_MSB:0];
        end
        if (res_vld && auto_mode_in && (res_data > peak_d)) begin
            peak_d = res_data;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            peak_q <= hcr_pkg::PEAK_RST;
        end else begin
            peak_q <= peak_d;
        end
    end

    // the pad driver only ever pulls low; rate flag is informative only,
    // the sampled logic behaves the same at every rate
    always_ff @(posedge sys_clk_in) begin
        sda_out <= 1'b0;
    end

    assign sda_oe_out         = oe_q;
    assign peak_value_out     = peak_q;
    assign high_rate_mode_out = hs_q;
endmodule

// ---- tb/hcr_target_port_asserts.sv ----
// concurrent checks on the register-port target pins
`timescale 1ns/10ps
module hcr_target_port_asserts (
    input wire logic        sys_clk_in,
    input wire logic        rstn_in,
    input wire logic        conv_clk_in,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_out,
    input wire logic        conv_valid_in,
    input wire logic [11:0] conv_data_in,
    input wire logic        auto_mode_in,
    input wire logic [11:0] peak_value_out,
    input wire logic        high_rate_mode_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [3:0] bits_q;
    logic [7:0] shift_q;
    logic       scl_q;
    logic       sda_q;
    logic       rise;
    logic       addr_ph;
    assign rise    = scl_in && !scl_q;
    assign addr_ph = bits_q < 4'h8;
    // bit count and first byte since the last start, taken from the raw wires
    always_ff @(posedge sys_clk_in) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        if (!rstn_in) begin
            bits_q <= 4'hf;
        end else if (scl_in && scl_q && sda_q && !sda_in) begin
            bits_q <= 4'h0;
        end else if (rise && bits_q != 4'hf) begin
            bits_q <= bits_q + 4'h1;
        end
        if (rise && addr_ph) begin
            shift_q <= {shift_q[6:0], sda_in};
        end
    end
    //////////////////////////////////////////////////////////////////////
    reset_clear_a: assert property ($rose(rstn_in) |-> !sda_oe_out
        && !high_rate_mode_out && peak_value_out == 12'h000) else $error("reset values wrong");
    drive_zero_a: assert property (sda_oe_out |-> sda_out == 1'b0)
        else $error("driven level not low");
    // answers move only while the clock is low, so no false start or stop
    low_change_a: assert property ($changed(sda_oe_out) |-> !scl_in && !scl_q)
        else $error("data drive changed with clock high");
    addr_quiet_a: assert property (addr_ph && $past(addr_ph, 4) |-> !sda_oe_out)
        else $error("data driven during address byte");
    ack_own_a: assert property (rise && bits_q == 4'h8
        && shift_q[7:1] == hcr_pkg::OWN_ADDR |-> !sda_in) else $error("own address not acked");
    nack_other_a: assert property (rise && bits_q == 4'h8
        && shift_q[7:1] != hcr_pkg::OWN_ADDR |-> sda_in) else $error("foreign address acked");
    hr_entry_a: assert property (rise && bits_q == 4'h8
        && shift_q[7:3] == hcr_pkg::MCODE_PFX |-> ##[0:30] high_rate_mode_out)
        else $error("entry code did not set high rate");
    hr_stop_a: assert property (scl_in && scl_q && !sda_q && sda_in
        |-> ##[1:8] !high_rate_mode_out) else $error("high rate kept after stop");
    peak_drop_a: assert property (peak_value_out < $past(peak_value_out) |-> !scl_in)
        else $error("peak fell without a bus write");
    peak_rise_a: assert property (peak_value_out > $past(peak_value_out)
        && scl_in && scl_q |-> auto_mode_in) else $error("peak rose outside automatic mode");
endmodule
bind hcr_target_port hcr_target_port_asserts hcr_target_port_asserts_i (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .conv_clk_in(conv_clk_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
    .auto_mode_in(auto_mode_in), .peak_value_out(peak_value_out),
    .high_rate_mode_out(high_rate_mode_out)
);

// ---- tb/hcr_bus_ctl.sv ----
// behavioural two-wire bus controller facing the target port
`timescale 1ns/10ps
module hcr_bus_ctl (
    input  wire logic clk_in,
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_out
);
    int h = 8; // quarter bit in system cycles, 5 at the high rate
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic dly(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // also serves as repeated start; clock stays high between frames
    task automatic start();
        dly(h);
        sda_out <= 1'b1;
        dly(h);
        scl_out <= 1'b1;
        dly(h);
        sda_out <= 1'b0;
        dly(h);
        scl_out <= 1'b0;
    endtask
    task automatic stop();
        dly(h);
        sda_out <= 1'b0;
        dly(h);
        scl_out <= 1'b1;
        dly(h);
        sda_out <= 1'b1;
        dly(2 * h);
    endtask
    task automatic xbit(input logic b, output logic r);
        dly(h);
        sda_out <= b;
        dly(h);
        scl_out <= 1'b1;
        dly(h);
        r = sda_line_in;
        dly(h);
        scl_out <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(b[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            xbit(1'b1, r);
            d = {d[6:0], r};
        end
        xbit(nack, r);
    endtask
endmodule

// ---- tb/hcr_target_port_test.sv ----
// self-checking bench for the register-port target
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
    end \
end
module hcr_target_port_test;
    logic        sys_clk_in    = 1'b0;
    logic        conv_clk_in   = 1'b0;
    logic        rstn_in       = 1'b0;
    logic        conv_valid_in = 1'b0;
    logic        auto_mode_in  = 1'b0;
    logic [11:0] conv_data_in  = 12'h000;
    logic [11:0] peak_value_out;
    logic        sda_out;
    logic        sda_oe_out;
    logic        high_rate_mode_out;
    logic        scl_w;
    logic        ctl_sda;
    logic        a;
    logic [7:0]  hi;
    // pulled up unless someone drives low; the pad value is used, so a wrong level shows
    wire         sda_w = ctl_sda & (sda_oe_out ? sda_out : 1'b1);
    int          error_cnt       = 0;
    int          samples_checked = 0;
    int          peak_m          = 0;
    int          ptr_m           = 0;
    int          seed            = 32'h57fed166;
    always #5 sys_clk_in = ~sys_clk_in;
    initial begin
        #3;
        forever #24 conv_clk_in = ~conv_clk_in;
    end
    hcr_target_port hcr_target_port_i (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .conv_clk_in(conv_clk_in),
        .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
        .auto_mode_in(auto_mode_in), .peak_value_out(peak_value_out),
        .high_rate_mode_out(high_rate_mode_out)
    );
    hcr_bus_ctl hcr_bus_ctl_i (
        .clk_in(sys_clk_in), .sda_line_in(sda_w), .scl_out(scl_w), .sda_out(ctl_sda)
    );
    //////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_word();
        return (ptr_m == 7) ? {4'h0, 12'(peak_m)} : 16'h0000;
    endfunction
    task automatic complete_run();
        $display("samples_checked=%0d error_cnt=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // spaced well apart: a result that lands while a transfer is in flight is lost
    task automatic conv(input logic [11:0] d);
        @(posedge conv_clk_in);
        conv_valid_in <= 1'b1;
        conv_data_in  <= d;
        @(posedge conv_clk_in);
        conv_valid_in <= 1'b0;
        repeat (12) @(posedge conv_clk_in);
        if (auto_mode_in && d > peak_m) peak_m = d;
        `CHK(peak_value_out, 12'(peak_m))
    endtask
    task automatic addr(input logic [6:0] ad, input logic rd, input logic ack);
        hcr_bus_ctl_i.start();
        hcr_bus_ctl_i.wbyte({ad, rd}, a);
        `CHK(a, ack)
    endtask
    task automatic wr_ptr(input logic [7:0] p);
        addr(hcr_pkg::OWN_ADDR, 1'b0, 1'b1);
        hcr_bus_ctl_i.wbyte(p, a);
        `CHK(a, 1'b1)
        ptr_m = p;
    endtask
    task automatic wr_pair(input logic [11:0] v, input logic hi_only);
        hcr_bus_ctl_i.wbyte({4'h0, v[11:8]}, a);
        `CHK(a, 1'b1)
        if (!hi_only) begin
            hcr_bus_ctl_i.wbyte(v[7:0], a);
            `CHK(a, 1'b1)
            if (ptr_m == 7) peak_m = v;
        end
    endtask
    task automatic rd_pairs(input int n);
        logic [7:0] lo;
        addr(hcr_pkg::OWN_ADDR, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            hcr_bus_ctl_i.rbyte(1'b0, hi);
            hcr_bus_ctl_i.rbyte(i == n - 1, lo);
            `CHK({hi, lo}, exp_word())
        end
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        error_cnt++;
        $display("[FAIL] %0t run did not finish", $time);
        complete_run();
    end
    initial begin
        repeat (4) @(posedge conv_clk_in);
        @(posedge sys_clk_in) rstn_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        `CHK({sda_oe_out, high_rate_mode_out, peak_value_out}, 14'h0000)
        wr_ptr(hcr_pkg::PEAK_PTR);
        rd_pairs(1);
        hcr_bus_ctl_i.stop();
        conv(12'h800 | 12'($random(seed)));
        @(posedge sys_clk_in) auto_mode_in <= 1'b1;
        for (int i = 0; i < 4; i++) conv(12'($random(seed)));
        conv(12'h001);
        wr_ptr(hcr_pkg::PEAK_PTR);
        wr_pair(12'($random(seed)), 1'b0);
        wr_pair(12'($random(seed)), 1'b0);
        hcr_bus_ctl_i.stop();
        `CHK(peak_value_out, 12'(peak_m))
        rd_pairs(3);
        hcr_bus_ctl_i.stop();
        wr_ptr(hcr_pkg::PEAK_PTR);
        wr_pair(12'($random(seed)), 1'b1);
        hcr_bus_ctl_i.stop();
        `CHK(peak_value_out, 12'(peak_m))
        wr_ptr(hcr_pkg::PEAK_PTR);
        wr_pair(12'h000, 1'b0);
        hcr_bus_ctl_i.stop();
        `CHK(peak_value_out, 12'h000)
        conv(12'h005);
        wr_ptr(8'h03);
        wr_pair(12'($random(seed)), 1'b0);
        rd_pairs(1);
        hcr_bus_ctl_i.stop();
        `CHK(peak_value_out, 12'(peak_m))
        wr_ptr(hcr_pkg::PEAK_PTR);
        hcr_bus_ctl_i.stop();
        addr(7'h55, 1'b0, 1'b0);
        hcr_bus_ctl_i.stop();
        addr(hcr_pkg::OWN_ADDR, 1'b1, 1'b1);
        hcr_bus_ctl_i.rbyte(1'b1, hi);
        hcr_bus_ctl_i.stop();
        `CHK(hi, 8'(exp_word() >> 8))
        hcr_bus_ctl_i.start();
        hcr_bus_ctl_i.wbyte(8'h08 | 8'($random(seed) & 7), a);
        `CHK(a, 1'b0)
        `CHK(high_rate_mode_out, 1'b1)
        hcr_bus_ctl_i.h = 5;
        wr_ptr(hcr_pkg::PEAK_PTR);
        wr_pair(12'($random(seed)), 1'b0);
        rd_pairs(2);
        `CHK(high_rate_mode_out, 1'b1)
        hcr_bus_ctl_i.stop();
        `CHK(high_rate_mode_out, 1'b0)
        hcr_bus_ctl_i.h = 8;
        rd_pairs(1);
        hcr_bus_ctl_i.stop();
        complete_run();
    end
endmodule
